// ### bcs_top.sv
// Bias calibration status registers behind an AXI4-Lite slave
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module bcs_top
	import bcs_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  sys_rst,

	input  wire logic [BCS_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [BCS_DATA_W-1:0] s_axi_wdata,
	input  wire logic [BCS_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [BCS_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [BCS_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,

	input  wire logic                  cal_done,
	input  wire logic                  cal_fail,
	input  wire logic [BCS_SET_W-1:0]  cal_chosen,
	input  wire logic [BCS_SET_W-1:0]  cal_applied,
	input  wire logic                  cal_comp_raw,

	output logic                       irq
);

	typedef struct packed {
		logic [BCS_ADDR_W-1:0] aw_addr;
		logic                  aw_held;
		logic [BCS_DATA_W-1:0] w_data;
		logic [BCS_STRB_W-1:0] w_strb;
		logic                  w_held;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [BCS_DATA_W-1:0] rdata;
		logic [1:0]            rresp;
		logic [BCS_STS_W-1:0]  status;
		logic [BCS_EVT_N-1:0]  irq_en;
	} bcs_top_state_t;

	bcs_top_state_t       st_q;
	bcs_top_state_t       st_d;
	logic                 comp_sync;
	logic                 aw_take;
	logic                 w_take;
	logic                 ar_take;
	logic                 do_wr;
	bcs_reg_t             wr_sel;
	bcs_reg_t             rd_sel;
	logic [BCS_STS_W-1:0] sts_next;
	logic [BCS_EVT_N-1:0] evt;
	logic [BCS_EVT_N-1:0] clr;

	bcs_irq_if irq_bus ();

	// Comparator is analog and unrelated to mclk
	bcs_sync #(
		.W (1)
	) u_comp_sync (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.async_in (cal_comp_raw),
		.sync_out (comp_sync)
	);

	bcs_irq_unit u_irq (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.bus     (irq_bus)
	);

	assign s_axi_awready = ~st_q.aw_held & ~st_q.bvalid;
	assign s_axi_wready  = ~st_q.w_held & ~st_q.bvalid;
	assign s_axi_arready = ~st_q.rvalid;

	assign aw_take = s_axi_awvalid & s_axi_awready;
	assign w_take  = s_axi_wvalid & s_axi_wready;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign do_wr   = st_q.aw_held & st_q.w_held & ~st_q.bvalid;
	assign wr_sel  = bcs_decode(st_q.aw_addr);
	assign rd_sel  = bcs_decode(s_axi_araddr);

	always_comb
	begin
		st_d     = st_q;
		sts_next = '0;
		evt      = '0;
		clr      = '0;

		// Settings and outcome only shown once finished
		sts_next[BCS_DONE_BIT] = cal_done;
		sts_next[BCS_FAIL_BIT] = cal_done & cal_fail;
		if (cal_done)
		begin
			sts_next[BCS_CHOSEN_LSB +: BCS_SET_W]  = cal_chosen;
			sts_next[BCS_APPLIED_LSB +: BCS_SET_W] = cal_applied;
		end
		sts_next[BCS_COMP_BIT] = comp_sync;
		// Status follows the engine only, never the bus
		st_d.status = sts_next;

		evt[BCS_EVT_DONE] = sts_next[BCS_DONE_BIT]
			& ~st_q.status[BCS_DONE_BIT];
		evt[BCS_EVT_FAIL] = sts_next[BCS_FAIL_BIT]
			& ~st_q.status[BCS_FAIL_BIT];
		evt[BCS_EVT_COMP] = sts_next[BCS_COMP_BIT]
			^ st_q.status[BCS_COMP_BIT];

		if (aw_take)
		begin
			st_d.aw_addr = s_axi_awaddr;
			st_d.aw_held = 1'b1;
		end
		if (w_take)
		begin
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
			st_d.w_held = 1'b1;
		end

		if (do_wr)
		begin
			st_d.aw_held = 1'b0;
			st_d.w_held  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = BCS_RESP_OKAY;
			case (wr_sel)
				BCS_REG_IRQ_EN:
				begin
					if (st_q.w_strb[0])
						st_d.irq_en = st_q.w_data[BCS_EVT_N-1:0];
				end
				BCS_REG_IRQ_CLR:
				begin
					if (st_q.w_strb[0])
						clr = st_q.w_data[BCS_EVT_N-1:0];
				end
				// Read-only registers accept and drop the data
				BCS_REG_STATUS:  st_d.bresp = BCS_RESP_OKAY;
				BCS_REG_IRQ_STS: st_d.bresp = BCS_RESP_OKAY;
				default:         st_d.bresp = BCS_RESP_SLVERR;
			endcase
		end
		else if (st_q.bvalid & s_axi_bready)
		begin
			st_d.bvalid = 1'b0;
		end

		if (ar_take)
		begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = '0;
			st_d.rresp  = BCS_RESP_OKAY;
			case (rd_sel)
				BCS_REG_STATUS:
					st_d.rdata[BCS_STS_W-1:0] = st_q.status;
				BCS_REG_IRQ_STS:
					st_d.rdata[BCS_EVT_N-1:0] = irq_bus.sts;
				BCS_REG_IRQ_EN:
					st_d.rdata[BCS_EVT_N-1:0] = st_q.irq_en;
				BCS_REG_IRQ_CLR:
					st_d.rdata = '0;
				default:
					st_d.rresp = BCS_RESP_SLVERR;
			endcase
		end
		else if (st_q.rvalid & s_axi_rready)
		begin
			st_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_q        <= '0;
			st_q.status <= BCS_STS_RESET;
			st_q.irq_en <= BCS_EVT_RESET;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign irq_bus.evt = evt;
	assign irq_bus.en  = st_q.irq_en;
	assign irq_bus.clr = clr;

	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp  = st_q.bresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata  = st_q.rdata;
	assign s_axi_rresp  = st_q.rresp;
	assign irq          = irq_bus.irq;
endmodule

// ### bcs_pkg.sv
// Constants, types and decode helpers for the bias calibration status block
//
// Notes on behaviour
// - Status bit 0 reads 0 while calibration runs, 1 once it has finished.
// - Status bit 1 gives the outcome, 0 success, 1 failure, once done.
// - Status bits 4:2 hold the setting chosen by calibration, once done.
// - Status bits 7:5 hold the setting applied to the bias circuit, once done.
// - Status bit 8 shows the raw calibration comparator output.
package bcs_pkg;

	localparam int BCS_ADDR_W = 12;
	localparam int BCS_DATA_W = 32;
	localparam int BCS_STRB_W = 4;

	localparam logic [11:0] BCS_OFS_STATUS  = 12'h000;
	localparam logic [11:0] BCS_OFS_IRQ_STS = 12'h004;
	localparam logic [11:0] BCS_OFS_IRQ_EN  = 12'h008;
	localparam logic [11:0] BCS_OFS_IRQ_CLR = 12'h00C;

	localparam int BCS_STS_W       = 16;
	localparam int BCS_SET_W       = 3;
	localparam int BCS_DONE_BIT    = 0;
	localparam int BCS_FAIL_BIT    = 1;
	localparam int BCS_CHOSEN_LSB  = 2;
	localparam int BCS_APPLIED_LSB = 5;
	localparam int BCS_COMP_BIT    = 8;
	localparam logic [15:0] BCS_STS_RESET = 16'h0000;

	localparam int BCS_EVT_N    = 3;
	localparam int BCS_EVT_DONE = 0;
	localparam int BCS_EVT_FAIL = 1;
	localparam int BCS_EVT_COMP = 2;
	localparam logic [2:0] BCS_EVT_RESET = 3'h0;

	localparam logic [1:0] BCS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] BCS_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BCS_REG_STATUS,
		BCS_REG_IRQ_STS,
		BCS_REG_IRQ_EN,
		BCS_REG_IRQ_CLR,
		BCS_REG_NONE
	} bcs_reg_t;

	function automatic bcs_reg_t bcs_decode(input logic [11:0] addr);
		bcs_reg_t sel;
		sel = BCS_REG_NONE;
		if (addr[1:0] == 2'h0)
		begin
			case (addr)
				BCS_OFS_STATUS:  sel = BCS_REG_STATUS;
				BCS_OFS_IRQ_STS: sel = BCS_REG_IRQ_STS;
				BCS_OFS_IRQ_EN:  sel = BCS_REG_IRQ_EN;
				BCS_OFS_IRQ_CLR: sel = BCS_REG_IRQ_CLR;
				default:         sel = BCS_REG_NONE;
			endcase
		end
		return sel;
	endfunction

endpackage

// ### bcs_irq_if.sv
// Interface between the status core and the interrupt unit
`timescale 1ns/1ps
interface bcs_irq_if;
	import bcs_pkg::*;

	logic [BCS_EVT_N-1:0] evt;
	logic [BCS_EVT_N-1:0] en;
	logic [BCS_EVT_N-1:0] clr;
	logic [BCS_EVT_N-1:0] sts;
	logic                 irq;

	modport core (output evt, output en, output clr, input sts, input irq);
	modport unit (input evt, input en, input clr, output sts, output irq);
endinterface

// ### bcs_sync.sv
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module bcs_sync
	import bcs_pkg::*;
#(
	parameter int W = 1
)
(
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} bcs_sync_state_t;

	bcs_sync_state_t st_q;
	bcs_sync_state_t st_d;

	always_comb
	begin
		st_d    = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign sync_out = st_q.s2;
endmodule

// ### bcs_irq_unit.sv
// Sticky interrupt status with enable gating onto one level output
`timescale 1ns/1ps
module bcs_irq_unit
	import bcs_pkg::*;
(
	input  wire logic mclk,
	input  wire logic sys_rst,
	bcs_irq_if.unit   bus
);

	typedef struct packed {
		logic [BCS_EVT_N-1:0] sts;
	} bcs_irq_state_t;

	bcs_irq_state_t st_q;
	bcs_irq_state_t st_d;

	always_comb
	begin
		st_d = st_q;
		// New event beats a clear in the same cycle
		st_d.sts = (st_q.sts & ~bus.clr) | bus.evt;
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
			st_q.sts <= BCS_EVT_RESET;
		else
			st_q <= st_d;
	end

	assign bus.sts = st_q.sts;
	assign bus.irq = |(st_q.sts & bus.en);
endmodule

// ### bcs_asserts.sv
// Assertions on the status read path of the bias calibration block
`timescale 1ns/1ps
module bcs_asserts
	import bcs_pkg::*;
(
	input wire logic        mclk,
	input wire logic        sys_rst,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        cal_done,
	input wire logic        cal_fail,
	input wire logic [2:0]  cal_chosen,
	input wire logic [2:0]  cal_applied,
	input wire logic        cal_comp_raw
);
	logic rd_sts_q;
	always_ff @(posedge mclk)
		if (sys_rst)
			rd_sts_q <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rd_sts_q <= s_axi_araddr == BCS_OFS_STATUS;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	done_bit_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[0] == $past(cal_done, 2)) else $error("done bit");
	fail_bit_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[1] == ($past(cal_fail, 2) && $past(cal_done, 2)))
		else $error("fail bit");
	chosen_set_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[4:2] ==
		($past(cal_done, 2) ? $past(cal_chosen, 2) : 3'h0)) else $error("chosen");
	applied_set_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[7:5] ==
		($past(cal_done, 2) ? $past(cal_applied, 2) : 3'h0)) else $error("applied");
	comp_raw_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[8] == $past(cal_comp_raw, 4)) else $error("comparator");
	status_top_a: assert property ($rose(s_axi_rvalid) && rd_sts_q
		|-> s_axi_rdata[31:9] == 23'h0) else $error("reserved bits");
endmodule

// ### tb_bcs_top.sv
// Self-checking bench for the bias calibration status block
`timescale 1ns/1ps
module tb_bcs_top
	import bcs_pkg::*;
;
	localparam logic [33:0] OK0 = 34'h0;
	localparam logic [33:0] RERR = {BCS_RESP_SLVERR, 32'h0};
	localparam logic [33:0] WERR = {32'h0, BCS_RESP_SLVERR};
	logic mclk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, cal_done, cal_fail, cal_comp_raw;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic [2:0]  cal_chosen, cal_applied;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [33:0] rq[$];
	logic [1:0]  wq[$];
	int          miscompares, total_checks;

	bcs_top DUT (.mclk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal_done, .cal_fail,
		.cal_chosen, .cal_applied, .cal_comp_raw, .irq);

	initial
	begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction

	task automatic chk(input string nm, input logic [33:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One AXI4-Lite transfer; the expectation goes to the monitor's queue
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [33:0] e);
		logic ak, wk, dk;
		int i;
		if (w)
		begin
			wq.push_back(e[1:0]);
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end
		else
		begin
			rq.push_back(e);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		dk = 1'b0;
		for (i = 0; i < 40 && !dk; i++)
		begin
			@(negedge mclk);
			ak = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
			wk = s_axi_wvalid && s_axi_wready;
			dk = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
			@(posedge mclk);
			if (ak)
				s_axi_awvalid <= 1'b0;
			if (ak)
				s_axi_arvalid <= 1'b0;
			if (wk)
				s_axi_wvalid <= 1'b0;
			if (dk)
				s_axi_bready <= 1'b0;
			if (dk)
				s_axi_rready <= 1'b0;
		end
		if (!dk)
		begin
			miscompares++;
			test_done();
		end
		@(posedge mclk);
	endtask

	task automatic irq_is(input logic e);
		@(negedge mclk);
		chk("irq", {33'h0, irq}, {33'h0, e});
		@(posedge mclk);
	endtask

	always @(posedge mclk)
	begin
		if (s_axi_rvalid && s_axi_rready)
			chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", {32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
	end

	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, cal_done, cal_fail} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		{cal_chosen, cal_applied, cal_comp_raw} = 7'h0;
		s_axi_wstrb = 4'hF;
		seed = 32'hDFFD;
		sys_rst = 1'b1;
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		xfer(0, BCS_OFS_STATUS, 0, {BCS_RESP_OKAY, 16'h0, BCS_STS_RESET});
		xfer(0, BCS_OFS_IRQ_EN, 0, OK0);
		$display("test reset done");
		xfer(1, BCS_OFS_IRQ_EN, 32'h1, OK0);
		cal_done <= 1'b1;
		repeat (4) @(posedge mclk);
		irq_is(1'b1);
		xfer(1, BCS_OFS_IRQ_EN, 32'h0, OK0);
		irq_is(1'b0);
		xfer(0, BCS_OFS_IRQ_STS, 0, 34'h1);
		xfer(1, BCS_OFS_IRQ_CLR, 32'h7, OK0);
		xfer(0, BCS_OFS_IRQ_STS, 0, OK0);
		xfer(1, BCS_OFS_IRQ_EN, 32'h1, OK0);
		irq_is(1'b0);
		$display("test interrupt done");
		xfer(1, BCS_OFS_STATUS, 32'hFFFFFFFF, OK0);
		xfer(0, BCS_OFS_STATUS, 0, 34'h1);
		xfer(0, 12'h010, 0, RERR);
		xfer(0, 12'h002, 0, RERR);
		xfer(1, 12'h014, 32'h1, WERR);
		$display("test access done");
		cal_fail <= 1'b1;
		cal_comp_raw <= 1'b1;
		repeat (6) @(posedge mclk);
		xfer(0, BCS_OFS_IRQ_STS, 0, 34'h6);
		s_axi_wstrb <= 4'hE;
		xfer(1, BCS_OFS_IRQ_EN, 32'h7, OK0);
		s_axi_wstrb <= 4'hF;
		xfer(0, BCS_OFS_IRQ_EN, 0, 34'h1);
		irq_is(1'b0);
		xfer(1, BCS_OFS_IRQ_EN, 32'h6, OK0);
		irq_is(1'b1);
		$display("test events done");
		repeat (12)
		begin
			seed = xs(seed);
			cal_done <= seed[0];
			cal_fail <= seed[1];
			cal_chosen <= seed[4:2];
			cal_applied <= seed[7:5];
			cal_comp_raw <= seed[8];
			repeat (5) @(posedge mclk);
			xfer(0, BCS_OFS_STATUS, 0, {BCS_RESP_OKAY, 23'h0, seed[8],
				seed[0] ? seed[7:1] : 7'h0, seed[0]});
		end
		$display("test random done");
		test_done();
	end
endmodule

bind bcs_top bcs_asserts u_chk (.mclk, .sys_rst, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
	.cal_done, .cal_fail, .cal_chosen, .cal_applied, .cal_comp_raw);
